// ---- rtl/icp_top.sv ----
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/10ps
`include "icp_defs.svh"

module icp_top
  import icp_pkg::*;
(
  input wire logic clk, // 50 MHz system clock
  input wire logic nrst, // async reset, active low
  input wire logic wb_cyc, // bus cycle
  input wire logic wb_stb, // bus strobe
  input wire logic wb_we, // write enable
  input wire logic [11:0] wb_adr, // byte address
  input wire logic [3:0] wb_sel, // byte lanes
  input wire logic [31:0] wb_dat_w, // write data
  output logic [31:0] wb_dat_r, // read data
  output logic wb_ack, // access answered
  input wire logic cap_pin, // capture input pin
  input wire logic gate_pin, // timer gate pin
  input wire logic cpu_sleep, // cpu in sleep
  output logic timer_irq, // high-timer request
  output logic cap_irq, // capture request
  output logic wake // wake pulse from sleep
);

  localparam icp_state_s ST_RST = '{
    plow: `ICP_PERIOD_RST,
    phigh: `ICP_PERIOD_RST,
    default: '0
  };

  icp_state_s q;
  icp_state_s n;

  logic acc;
  logic wr;
  logic rd;
  logic [9:0] idx;
  logic [2:0] mode;
  logic casc;
  logic run_lo;
  logic run_hi;
  logic gate_fall;
  logic rise;
  logic fall;
  logic thigh_evt;
  logic cap_evt;
  logic cap_irq_evt;
  logic push;
  logic pop;
  logic full;
  logic empty;
  logic [15:0] tbase;
  logic [15:0] fifo_head;
  logic [2:0] fifo_cnt;

  function automatic logic [15:0] wmerge(
    input logic [15:0] old,
    input logic [15:0] nv,
    input logic [1:0] sel
  );
    logic [15:0] m;
    m = {{8{sel[1]}}, {8{sel[0]}}};
    wmerge = (old & ~m) | (nv & m);
  endfunction

  // ----------------------------------------
  // capture buffer
  // ----------------------------------------
  icp_fifo u_fifo (
    .clk(clk),
    .nrst(nrst),
    .push(push),
    .pop(pop),
    .din(tbase),
    .dout(fifo_head),
    .count(fifo_cnt)
  );

  assign full = (fifo_cnt == `ICP_FIFO_DEPTH);
  assign empty = (fifo_cnt == 3'h0);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    n = q;
    thigh_evt = 1'b0;
    cap_evt = 1'b0;
    cap_irq_evt = 1'b0;
    push = 1'b0;
    pop = 1'b0;

    // pins pass two flops before any logic looks at them
    n.pin_s1 = cap_pin;
    n.pin_s2 = q.pin_s1;
    n.pin_prev = q.pin_s2;
    n.gate_s1 = gate_pin;
    n.gate_s2 = q.gate_s1;
    n.gate_prev = q.gate_s2;

    mode = q.cap_ctrl[2:0];
    casc = q.tcon_low[`ICP_CASCADE_BIT];
    rise = q.pin_s2 & ~q.pin_prev;
    fall = ~q.pin_s2 & q.pin_prev;
    run_lo = q.tcon_low[`ICP_ON_BIT] & ~cpu_sleep;
    run_lo = run_lo & (~q.tcon_low[`ICP_GATE_EN_BIT] | q.gate_s2);
    run_hi = q.tcon_high[`ICP_ON_BIT] & ~cpu_sleep;
    gate_fall = q.tcon_low[`ICP_ON_BIT] & q.tcon_low[`ICP_GATE_EN_BIT];
    gate_fall = gate_fall & q.gate_prev & ~q.gate_s2;

    // ----------------------------------------
    // timer pair
    // ----------------------------------------
    if (casc) begin
      if (run_lo) begin
        if ({q.thigh, q.tlow} == {q.phigh, q.plow}) begin
          {n.thigh, n.tlow} = 32'h0000_0000;
          thigh_evt = 1'b1;
        end else begin
          {n.thigh, n.tlow} = {q.thigh, q.tlow} + 32'h0000_0001;
        end
      end
      if (gate_fall) begin
        thigh_evt = 1'b1;
      end
    end else begin
      if (run_lo) begin
        if (q.tlow == q.plow) begin
          n.tlow = 16'h0000;
        end else begin
          n.tlow = q.tlow + 16'h0001;
        end
      end
      if (run_hi) begin
        if (q.thigh == q.phigh) begin
          n.thigh = 16'h0000;
          thigh_evt = 1'b1;
        end else begin
          n.thigh = q.thigh + 16'h0001;
        end
      end
    end

    // ----------------------------------------
    // capture edges and prescaler
    // ----------------------------------------
    // select bit set picks the low timer; reset value picks the high one
    tbase = q.cap_ctrl[`ICP_CAP_TSEL_BIT] ? q.tlow : q.thigh;
    if (mode == `ICP_MODE_OFF) begin
      n.pscl = 4'h0;
      n.evt_cnt = 2'h0;
    end else if (rise && (mode == `ICP_MODE_RISE4 || mode == `ICP_MODE_RISE16)) begin
      n.pscl = q.pscl + 4'h1;
    end
    case (mode)
      `ICP_MODE_EDGE: cap_evt = rise | fall;
      `ICP_MODE_FALL: cap_evt = fall;
      `ICP_MODE_RISE: cap_evt = rise;
      `ICP_MODE_RISE4: cap_evt = rise & (q.pscl[1:0] == 2'h3);
      `ICP_MODE_RISE16: cap_evt = rise & (q.pscl == 4'hF);
      default: cap_evt = 1'b0;
    endcase
    // only the interrupt-only mode keeps working in sleep
    cap_evt = cap_evt & ~cpu_sleep;
    push = cap_evt & ~full & ~q.cap_ovf;

    if (mode == `ICP_MODE_EDGE) begin
      cap_irq_evt = cap_evt;
    end else if (mode == `ICP_MODE_IRQ_ONLY) begin
      cap_irq_evt = rise;
      n.wake = cpu_sleep & rise & q.cap_irq_en;
    end else if (push) begin
      if (q.evt_cnt == q.cap_ctrl[`ICP_CAP_ICNT_HI:`ICP_CAP_ICNT_LO]) begin
        cap_irq_evt = 1'b1;
        n.evt_cnt = 2'h0;
      end else begin
        n.evt_cnt = q.evt_cnt + 2'h1;
      end
    end
    if (mode != `ICP_MODE_IRQ_ONLY) begin
      n.wake = 1'b0;
    end

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    acc = wb_cyc & wb_stb & ~q.ack;
    wr = acc & wb_we;
    rd = acc & ~wb_we;
    idx = wb_adr[11:2];
    n.ack = acc;
    n.rdat = 32'h0000_0000;

    if (rd) begin
      case (idx)
        `ICP_IDX_TLOW: begin
          n.rdat[15:0] = q.tlow;
          if (casc) begin
            n.hold = q.thigh;
          end
        end
        `ICP_IDX_THOLD: n.rdat[15:0] = q.hold;
        `ICP_IDX_THIGH: n.rdat[15:0] = q.thigh;
        `ICP_IDX_PLOW: n.rdat[15:0] = q.plow;
        `ICP_IDX_PHIGH: n.rdat[15:0] = q.phigh;
        `ICP_IDX_TCON_LOW: n.rdat[15:0] = q.tcon_low;
        `ICP_IDX_TCON_HIGH: n.rdat[15:0] = q.tcon_high;
        `ICP_IDX_IRQ_FLAG: begin
          n.rdat[`ICP_IRQ_THIGH_BIT] = q.thigh_irq_flag;
          n.rdat[`ICP_IRQ_CAP_BIT] = q.cap_irq_flag;
        end
        `ICP_IDX_IRQ_EN: begin
          n.rdat[`ICP_IRQ_THIGH_BIT] = q.thigh_irq_en;
          n.rdat[`ICP_IRQ_CAP_BIT] = q.cap_irq_en;
        end
        `ICP_IDX_CAP_BUF: begin
          // an empty read returns zero and pops nothing
          n.rdat[15:0] = fifo_head;
          pop = ~empty;
        end
        `ICP_IDX_CAP_CTRL: begin
          n.rdat[15:0] = q.cap_ctrl;
          n.rdat[`ICP_CAP_OVF_BIT] = q.cap_ovf;
          n.rdat[`ICP_CAP_BNE_BIT] = ~empty;
        end
        default: n.rdat = 32'h0000_0000;
      endcase
    end

    if (wr) begin
      case (idx)
        `ICP_IDX_TLOW: begin
          n.tlow = wmerge(q.tlow, wb_dat_w[15:0], wb_sel[1:0]);
          if (casc) begin
            n.thigh = q.hold;
          end
        end
        `ICP_IDX_THOLD: n.hold = wmerge(q.hold, wb_dat_w[15:0], wb_sel[1:0]);
        `ICP_IDX_THIGH: n.thigh = wmerge(q.thigh, wb_dat_w[15:0], wb_sel[1:0]);
        `ICP_IDX_PLOW: n.plow = wmerge(q.plow, wb_dat_w[15:0], wb_sel[1:0]);
        `ICP_IDX_PHIGH: n.phigh = wmerge(q.phigh, wb_dat_w[15:0], wb_sel[1:0]);
        `ICP_IDX_TCON_LOW: begin
          n.tcon_low = wmerge(q.tcon_low, wb_dat_w[15:0], wb_sel[1:0]);
          n.tcon_low = n.tcon_low & `ICP_TCON_LOW_WMASK;
        end
        `ICP_IDX_TCON_HIGH: begin
          n.tcon_high = wmerge(q.tcon_high, wb_dat_w[15:0], wb_sel[1:0]);
          n.tcon_high = n.tcon_high & `ICP_TCON_HIGH_WMASK;
        end
        `ICP_IDX_IRQ_FLAG: begin
          if (wb_sel[0]) begin
            n.thigh_irq_flag = wb_dat_w[`ICP_IRQ_THIGH_BIT];
            n.cap_irq_flag = wb_dat_w[`ICP_IRQ_CAP_BIT];
          end
        end
        `ICP_IDX_IRQ_EN: begin
          if (wb_sel[0]) begin
            n.thigh_irq_en = wb_dat_w[`ICP_IRQ_THIGH_BIT];
            n.cap_irq_en = wb_dat_w[`ICP_IRQ_CAP_BIT];
          end
        end
        `ICP_IDX_CAP_CTRL: begin
          n.cap_ctrl = wmerge(q.cap_ctrl, wb_dat_w[15:0], wb_sel[1:0]);
          n.cap_ctrl = n.cap_ctrl & `ICP_CAP_CTRL_WMASK;
        end
        default: n.cap_ctrl = n.cap_ctrl;
      endcase
    end

    // ----------------------------------------
    // sticky flags, set wins over clear
    // ----------------------------------------
    // overflow releases once the buffer has been drained or the mode is off
    if ((pop && fifo_cnt == 3'h1) || mode == `ICP_MODE_OFF) begin
      n.cap_ovf = 1'b0;
    end
    if (cap_evt && full && mode != `ICP_MODE_EDGE) begin
      n.cap_ovf = 1'b1;
    end
    if (thigh_evt) begin
      n.thigh_irq_flag = 1'b1;
    end
    if (cap_irq_evt) begin
      n.cap_irq_flag = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= ST_RST;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign wb_dat_r = q.rdat;
  assign wb_ack = q.ack;
  assign timer_irq = q.thigh_irq_flag & q.thigh_irq_en;
  assign cap_irq = q.cap_irq_flag & q.cap_irq_en;
  assign wake = q.wake;

endmodule

// ---- rtl/icp_defs.svh ----
`ifndef ICP_DEFS_SVH
`define ICP_DEFS_SVH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define ICP_IDX_TLOW 10'h106
`define ICP_IDX_THOLD 10'h108
`define ICP_IDX_THIGH 10'h10A
`define ICP_IDX_PLOW 10'h10C
`define ICP_IDX_PHIGH 10'h10E
`define ICP_IDX_TCON_LOW 10'h110
`define ICP_IDX_TCON_HIGH 10'h112
`define ICP_IDX_IRQ_FLAG 10'h084
`define ICP_IDX_IRQ_EN 10'h094
`define ICP_IDX_CAP_BUF 10'h140
`define ICP_IDX_CAP_CTRL 10'h142

// ----------------------------------------
// timer control fields
// ----------------------------------------
`define ICP_ON_BIT 15
`define ICP_IDLE_STOP_BIT 13
`define ICP_GATE_EN_BIT 6
`define ICP_CASCADE_BIT 3
`define ICP_TCON_LOW_WMASK 16'hA07A
`define ICP_TCON_HIGH_WMASK 16'hA072

// ----------------------------------------
// capture control fields
// ----------------------------------------
`define ICP_CAP_TSEL_BIT 7
`define ICP_CAP_ICNT_HI 6
`define ICP_CAP_ICNT_LO 5
`define ICP_CAP_OVF_BIT 4
`define ICP_CAP_BNE_BIT 3
`define ICP_CAP_CTRL_WMASK 16'h20E7
`define ICP_MODE_OFF 3'h0
`define ICP_MODE_EDGE 3'h1
`define ICP_MODE_FALL 3'h2
`define ICP_MODE_RISE 3'h3
`define ICP_MODE_RISE4 3'h4
`define ICP_MODE_RISE16 3'h5
`define ICP_MODE_IRQ_ONLY 3'h7

// ----------------------------------------
// interrupt bits, reset values, sizes
// ----------------------------------------
`define ICP_IRQ_CAP_BIT 1
`define ICP_IRQ_THIGH_BIT 7
`define ICP_PERIOD_RST 16'hFFFF
`define ICP_FIFO_DEPTH 3'h4

`endif

// ---- rtl/icp_pkg.sv ----
package icp_pkg;

  typedef struct packed {
    logic [15:0] tlow;
    logic [15:0] thigh;
    logic [15:0] hold;
    logic [15:0] plow;
    logic [15:0] phigh;
    logic [15:0] tcon_low;
    logic [15:0] tcon_high;
    logic [15:0] cap_ctrl;
    logic thigh_irq_flag;
    logic thigh_irq_en;
    logic cap_irq_flag;
    logic cap_irq_en;
    logic cap_ovf;
    logic [3:0] pscl;
    logic [1:0] evt_cnt;
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    logic gate_s1;
    logic gate_s2;
    logic gate_prev;
    logic wake;
    logic ack;
    logic [31:0] rdat;
  } icp_state_s;

  typedef struct packed {
    logic [3:0][15:0] ent;
    logic [2:0] cnt;
  } icp_fifo_s;

endpackage

// ---- rtl/icp_fifo.sv ----
`timescale 1ns/10ps
`include "icp_defs.svh"

module icp_fifo
  import icp_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic push, // store din
  input wire logic pop, // drop oldest entry
  input wire logic [15:0] din, // captured time
  output logic [15:0] dout, // oldest entry
  output logic [2:0] count // entries held
);

  icp_fifo_s q;
  icp_fifo_s n;

  // ----------------------------------------
  // shift-forward storage
  // ----------------------------------------
  always_comb begin
    n = q;
    if (pop && q.cnt != 3'h0) begin
      n.ent = {16'h0000, q.ent[3:1]};
      n.cnt = q.cnt - 3'h1;
    end
    // a push into a full buffer is dropped here; the caller flags it except in the both-edges mode
    if (push && n.cnt != `ICP_FIFO_DEPTH) begin
      n.ent[n.cnt[1:0]] = din;
      n.cnt = n.cnt + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign dout = q.ent[0];
  assign count = q.cnt;

endmodule

// ---- tb/icp_top_properties.sv ----
`timescale 1ns/10ps
`include "icp_defs.svh"
module icp_chk
  import icp_pkg::*;
(
  input wire logic clk, // clock
  input wire logic nrst, // reset
  input wire logic wb_cyc, // cycle
  input wire logic wb_stb, // strobe
  input wire logic wb_we, // write
  input wire logic [11:0] wb_adr, // address
  input wire logic [3:0] wb_sel, // lanes
  input wire logic [31:0] wb_dat_w, // wdata
  input wire logic [31:0] wb_dat_r, // rdata
  input wire logic wb_ack, // answer
  input wire logic cpu_sleep, // sleep
  input wire logic timer_irq, // timer irq
  input wire logic wake // wake
);
  // ----
  // properties
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_ack;
    wb_cyc && wb_stb && !wb_ack |=> wb_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_ack1;
    wb_ack |=> !wb_ack;
  endproperty
  a_ack1: assert property (p_ack1) else $error("ack too long");
  property p_rz;
    !wb_ack |-> wb_dat_r == 32'h0;
  endproperty
  a_rz: assert property (p_rz) else $error("data outside ack");
  property p_hi;
    wb_dat_r[31:16] == 16'h0;
  endproperty
  a_hi: assert property (p_hi) else $error("upper data set");
  property p_ten;
    wb_cyc && wb_stb && !wb_ack && wb_we && wb_sel[0] && wb_adr[11:2] == `ICP_IDX_IRQ_EN
      && !wb_dat_w[7] |=> !timer_irq;
  endproperty
  a_ten: assert property (p_ten) else $error("irq not masked");
  property p_tst;
    $fell(timer_irq) |-> wb_ack && $past(wb_we);
  endproperty
  a_tst: assert property (p_tst) else $error("flag cleared alone");
  property p_wk;
    wake |-> $past(cpu_sleep);
  endproperty
  a_wk: assert property (p_wk) else $error("wake while awake");
  property p_wk1;
    wake |=> !wake;
  endproperty
  a_wk1: assert property (p_wk1) else $error("wake too long");
endmodule

bind icp_top icp_chk u_icp_chk (.clk(clk), .nrst(nrst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
  .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
  .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .cpu_sleep(cpu_sleep), .timer_irq(timer_irq),
  .wake(wake));

// ---- tb/icp_edge_src.sv ----
`timescale 1ns/10ps
module icp_edge_src
  import icp_pkg::*;
(
  input wire logic clk, // clock
  input wire logic want, // level asked for
  output logic pin, // capture pin
  output logic done // level settled
);
  logic [2:0] hold_q;
  initial begin
    pin = 1'b0;
    hold_q = 3'h0;
  end
  // five cycles: sync and edge stages must have seen it
  always @(posedge clk) begin
    if (pin != want) begin
      pin <= want;
      hold_q <= 3'h0;
    end else if (hold_q != 3'h5) begin
      hold_q <= hold_q + 3'h1;
    end
  end
  assign done = (pin == want) && (hold_q == 3'h5);
endmodule

// ---- tb/icp_top_tb_top.sv ----
`timescale 1ns/10ps
`include "icp_defs.svh"
module icp_top_tb_top
  import icp_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dw = 32'h0;
  logic [31:0] dr;
  logic want = 1'b0;
  logic gate = 1'b0;
  logic sleep = 1'b0;
  logic ack, pin, tirq, cirq, wake, done;
  logic [15:0] q;
  logic [2:0] md[5] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h1};
  int pp[5] = '{1, 1, 4, 16, 1};
  int ne[5] = '{1, 1, 1, 1, 2};
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  int wakes = 0;
  always #10 clk = ~clk;
  icp_top u_icp_top (.clk(clk), .nrst(nrst), .wb_cyc(cyc), .wb_stb(stb), .wb_we(we),
    .wb_adr(adr), .wb_sel(sel), .wb_dat_w(dw), .wb_dat_r(dr), .wb_ack(ack),
    .cap_pin(pin), .gate_pin(gate), .cpu_sleep(sleep), .timer_irq(tirq),
    .cap_irq(cirq), .wake(wake));
  icp_edge_src u_icp_edge_src (.clk(clk), .want(want), .pin(pin), .done(done));
  // ----
  // helpers
  // ----
  task automatic end_of_test();
    if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chb(input string nm, input logic s, input logic e);
    chk(nm, {15'h0, s}, {15'h0, e});
  endtask
  // no local limit: a missing ack is caught by the cycle ceiling below
  task automatic bus(input logic w, input logic [9:0] i, input logic [15:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    sel <= 4'h3;
    dw <= {16'h0, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dr[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] i, input logic [15:0] d);
    bus(1'b1, i, d);
  endtask
  task automatic rd(input logic [9:0] i);
    bus(1'b0, i, 16'h0);
  endtask
  task automatic lvl(input logic v);
    @(posedge clk);
    want <= v;
    do begin
      @(posedge clk);
    end while (done !== 1'b1);
  endtask
  task automatic pls(input int p);
    repeat (p) begin
      lvl(1'b1);
      lvl(1'b0);
    end
  endtask
  task automatic drain();
    repeat (4) begin
      rd(`ICP_IDX_CAP_CTRL);
      if (q[3] === 1'b1) rd(`ICP_IDX_CAP_BUF);
    end
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_regs();
    rd(`ICP_IDX_PLOW);
    chk("period_low", q, 16'hFFFF);
    rd(`ICP_IDX_PHIGH);
    chk("period_high", q, 16'hFFFF);
    rd(`ICP_IDX_TCON_HIGH);
    chk("high_timer_control", q, 16'h0000);
    rd(`ICP_IDX_CAP_CTRL);
    chk("capture_control_reg", q, 16'h0000);
    wr(`ICP_IDX_CAP_CTRL, 16'hFFFF);
    rd(`ICP_IDX_CAP_CTRL);
    chk("capture_control_reg", q, `ICP_CAP_CTRL_WMASK);
    wr(`ICP_IDX_CAP_CTRL, 16'h0000);
    wr(`ICP_IDX_TCON_LOW, 16'hFFFF);
    rd(`ICP_IDX_TCON_LOW);
    chk("low_timer_control", q, `ICP_TCON_LOW_WMASK);
    wr(`ICP_IDX_TCON_LOW, 16'h0000);
    rd(10'h3FF);
    chk("unmapped", q, 16'h0000);
  endtask
  task automatic t_fifo();
    wr(`ICP_IDX_CAP_CTRL, 16'h0003);
    for (int k = 1; k <= 6; k++) begin
      wr(`ICP_IDX_THIGH, 16'hA000 + 16'(k));
      pls(1);
    end
    rd(`ICP_IDX_CAP_CTRL);
    chk("capture_control_reg", q, 16'h001B);
    for (int k = 1; k <= 4; k++) begin
      rd(`ICP_IDX_CAP_BUF);
      chk("capture", q, 16'hA000 + 16'(k));
      if (k == 1) pls(1);
    end
    rd(`ICP_IDX_CAP_CTRL);
    chk("capture_control_reg", q, 16'h0003);
    wr(`ICP_IDX_CAP_CTRL, 16'h0083);
    wr(`ICP_IDX_TLOW, 16'h5A5A);
    pls(1);
    rd(`ICP_IDX_CAP_BUF);
    chk("capture", q, 16'h5A5A);
  endtask
  task automatic t_modes();
    for (int j = 0; j < 5; j++) begin
      // start each mode from a cleared prescaler
      wr(`ICP_IDX_CAP_CTRL, 16'h0000);
      wr(`ICP_IDX_THIGH, {12'h0B0, 4'(j)});
      wr(`ICP_IDX_CAP_CTRL, {13'h0, md[j]});
      pls(pp[j] - 1);
      wr(`ICP_IDX_CAP_CTRL, 16'h0000);
      wr(`ICP_IDX_CAP_CTRL, {13'h0, md[j]});
      pls(pp[j] - 1);
      rd(`ICP_IDX_CAP_CTRL);
      chb("not empty", q[3], 1'b0);
      pls(1);
      repeat (ne[j]) begin
        rd(`ICP_IDX_CAP_BUF);
        chk("capture", q, {12'h0B0, 4'(j)});
      end
      rd(`ICP_IDX_CAP_CTRL);
      chb("not empty", q[3], 1'b0);
    end
  endtask
  task automatic t_irq();
    // earlier scenarios left the capture flag set
    wr(`ICP_IDX_IRQ_FLAG, 16'h0000);
    wr(`ICP_IDX_IRQ_EN, 16'h0002);
    wr(`ICP_IDX_CAP_CTRL, 16'h0023);
    pls(1);
    chb("cap irq", cirq, 1'b0);
    pls(1);
    chb("cap irq", cirq, 1'b1);
    wr(`ICP_IDX_IRQ_FLAG, 16'h0000);
    drain();
    wr(`ICP_IDX_CAP_CTRL, 16'h0061);
    lvl(1'b1);
    chb("cap irq", cirq, 1'b1);
    wr(`ICP_IDX_IRQ_FLAG, 16'h0000);
    lvl(1'b0);
    chb("cap irq", cirq, 1'b1);
    pls(4);
    rd(`ICP_IDX_CAP_CTRL);
    chb("overflow", q[4], 1'b0);
    wr(`ICP_IDX_IRQ_FLAG, 16'h0000);
    drain();
  endtask
  task automatic t_timer();
    sleep <= 1'b1;
    wr(`ICP_IDX_TCON_LOW, 16'h8008);
    wr(`ICP_IDX_THOLD, 16'h00AB);
    wr(`ICP_IDX_TLOW, 16'h0000);
    repeat (8) @(posedge clk);
    rd(`ICP_IDX_TLOW);
    chk("low count", q, 16'h0000);
    rd(`ICP_IDX_THIGH);
    chk("high count", q, 16'h00AB);
    wr(`ICP_IDX_THOLD, 16'h0000);
    rd(`ICP_IDX_TLOW);
    rd(`ICP_IDX_THOLD);
    chk("holding", q, 16'h00AB);
    wr(`ICP_IDX_PHIGH, 16'h00AB);
    wr(`ICP_IDX_PLOW, 16'h0020);
    sleep <= 1'b0;
    repeat (40) @(posedge clk);
    rd(`ICP_IDX_IRQ_FLAG);
    chb("timer flag", q[7], 1'b1);
    chb("timer irq", tirq, 1'b0);
    wr(`ICP_IDX_IRQ_EN, 16'h0080);
    repeat (40) @(posedge clk);
    chb("timer irq", tirq, 1'b1);
    wr(`ICP_IDX_IRQ_FLAG, 16'h0000);
    chb("timer irq", tirq, 1'b0);
    wr(`ICP_IDX_TCON_LOW, 16'h8048);
    gate <= 1'b1;
    repeat (4) @(posedge clk);
    gate <= 1'b0;
    repeat (6) @(posedge clk);
    chb("timer irq", tirq, 1'b1);
    wr(`ICP_IDX_TCON_LOW, 16'h0000);
    wr(`ICP_IDX_IRQ_FLAG, 16'h0000);
    // 16-bit high timer on its own control word
    sleep <= 1'b1;
    wr(`ICP_IDX_THIGH, 16'h0000);
    wr(`ICP_IDX_PHIGH, 16'h0004);
    wr(`ICP_IDX_TCON_HIGH, 16'h8000);
    repeat (10) @(posedge clk);
    rd(`ICP_IDX_THIGH);
    chk("high count", q, 16'h0000);
    sleep <= 1'b0;
    repeat (10) @(posedge clk);
    rd(`ICP_IDX_IRQ_FLAG);
    chb("timer flag", q[7], 1'b1);
    wr(`ICP_IDX_TCON_HIGH, 16'h0000);
    wr(`ICP_IDX_IRQ_FLAG, 16'h0000);
  endtask
  task automatic t_sleep();
    wr(`ICP_IDX_IRQ_EN, 16'h0002);
    wr(`ICP_IDX_CAP_CTRL, 16'h0003);
    sleep <= 1'b1;
    pls(1);
    rd(`ICP_IDX_CAP_CTRL);
    chb("not empty", q[3], 1'b0);
    wr(`ICP_IDX_CAP_CTRL, 16'h0007);
    pls(1);
    chk("wakes", 16'(wakes), 16'h0001);
    chb("cap irq", cirq, 1'b1);
    sleep <= 1'b0;
    rd(`ICP_IDX_CAP_CTRL);
    chb("not empty", q[3], 1'b0);
    wr(`ICP_IDX_IRQ_FLAG, 16'h0000);
  endtask
  always @(posedge clk) begin
    if (wake === 1'b1) wakes++;
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_fifo();
    t_modes();
    t_irq();
    t_timer();
    t_sleep();
    end_of_test();
  end
endmodule
